// >>> hw/mqf_device.sv
// Device end: eight queues, mark/retransmit, mailbox and output buffer
`timescale 1ns/100ps
module mqf_device (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               reset,
   // Link to the host
   mqf_if.dev                      lnk,
   // Device status
   output logic [mqf_pkg::PW_W-1:0] port_width_active,
   output logic                     mark_valid_any
);
   import mqf_pkg::*;

   // ************************************************
   // Helpers
   // ************************************************
   // Words held in a queue from its two wrapping pointers
   function automatic mqf_ptr_t occupancy(input mqf_ptr_t wp,
                                          input mqf_ptr_t rp);
      occupancy = mqf_ptr_t'(wp - rp);
   endfunction

   // Flat memory address of a queue slot
   function automatic logic [ADDR_W-1:0] slot_addr(input mqf_qsel_t q,
                                                   input mqf_ptr_t p);
      slot_addr = {q, p[PTR_W-1:0]};
   endfunction

   // ************************************************
   // State
   // ************************************************
   mqf_word_t         mem [0:NUM_Q*Q_DEPTH-1];
   mqf_ptr_t          wr_ptr_q   [NUM_Q];
   mqf_ptr_t          rd_ptr_q   [NUM_Q];
   mqf_ptr_t          mark_ptr_q [NUM_Q];
   logic [NUM_Q-1:0]  mark_vld_q;
   logic              clear_prev_q;
   logic [PW_W-1:0]   width_q;
   mqf_word_t         mb_data_q;
   mqf_qsel_t         mb_tag_q;
   logic              mb_vld_q;
   mqf_word_t         head_data_q;
   mqf_qsel_t         head_tag_q;
   logic              head_vld_n_q;
   mqf_word_t         tail_data_q;
   mqf_qsel_t         tail_tag_q;
   logic              tail_vld_q;
   logic              full_n_q;
   logic              empty_n_q;

   // ************************************************
   // Decode of the current requests
   // ************************************************
   wire mqf_qsel_t wq          = lnk.write_queue_select;
   wire mqf_qsel_t rq          = lnk.read_queue_select;
   wire logic      mb_mode     = lnk.mailbox_path_select;
   wire logic      clearing    = reset | lnk.master_clear;
   wire mqf_ptr_t  wq_occ      = occupancy(wr_ptr_q[wq], rd_ptr_q[wq]);
   wire mqf_ptr_t  rq_occ      = occupancy(wr_ptr_q[rq], rd_ptr_q[rq]);
   wire logic      wq_full     = (wq_occ == DEPTH_CNT);
   wire logic      rq_empty    = (rq_occ == PTR_RESET);
   // Buffer space: only the tail slot decides, so a full buffer stalls
   wire logic      buf_ready   = ~tail_vld_q;
   wire logic      buf_pop     = ~head_vld_n_q & lnk.data_ready;
   // Memory writes are inhibited while the queue is full
   wire logic      mem_write   = lnk.write_en & ~mb_mode & ~wq_full;
   // A pending mailbox word has the buffer first, so no queue read then
   wire logic      mem_read    = lnk.read_en & ~mb_mode & ~rq_empty
                                 & buf_ready & ~mb_vld_q;
   wire logic      mb_write    = lnk.write_en & mb_mode;
   wire logic      mb_push     = mb_vld_q & buf_ready;
   // Stage may take a new word when empty or when it moves on now
   wire logic      mb_take     = mb_write & (~mb_vld_q | mb_push);
   wire logic      buf_push    = mem_read | mb_push;
   wire mqf_word_t push_data   = mb_vld_q ? mb_data_q
                                 : mem[slot_addr(rq, rd_ptr_q[rq])];
   wire mqf_qsel_t push_tag    = mb_vld_q ? mb_tag_q : rq;
   wire logic      do_retx     = lnk.retransmit_request & mark_vld_q[rq]
                                 & ~mb_mode;
   wire logic      do_mark     = lnk.mark & ~mb_mode;

   // ************************************************
   // Queue memory write
   // ************************************************
   // Memory carries no reset; the pointers define what is valid
   always_ff @(posedge core_clk) begin
      if (mem_write) begin
         mem[slot_addr(wq, wr_ptr_q[wq])] <= lnk.write_data;
      end
   end

   // ************************************************
   // Pointers, mark and retransmit per queue
   // ************************************************
   // Retransmit takes priority over the read advance in the same cycle
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NUM_Q; i++) begin
         if (clearing) begin
            wr_ptr_q[i]   <= PTR_RESET;
            rd_ptr_q[i]   <= PTR_RESET;
            mark_ptr_q[i] <= PTR_RESET;
            mark_vld_q[i] <= 1'b0;
         end else begin
            if (mem_write && wq == QSEL_W'(i)) begin
               wr_ptr_q[i] <= mqf_ptr_t'(wr_ptr_q[i] + 1'b1);
            end
            if (do_mark && rq == QSEL_W'(i)) begin
               mark_ptr_q[i] <= rd_ptr_q[i];
               mark_vld_q[i] <= 1'b1;
            end
            if (do_retx && rq == QSEL_W'(i)) begin
               rd_ptr_q[i] <= mark_ptr_q[i];
            end else if (mem_read && rq == QSEL_W'(i)) begin
               rd_ptr_q[i] <= mqf_ptr_t'(rd_ptr_q[i] + 1'b1);
            end
         end
      end
   end

   // ************************************************
   // Port width capture
   // ************************************************
   // Captured only as master clear is released; later changes ignored
   always_ff @(posedge core_clk) begin
      if (reset) begin
         clear_prev_q <= 1'b0;
         width_q      <= PW_RESET;
      end else begin
         clear_prev_q <= lnk.master_clear;
         if (clear_prev_q && !lnk.master_clear) begin
            width_q <= lnk.port_width_select;
         end
      end
   end

   // ************************************************
   // Mailbox stage
   // ************************************************
   // Stage edge plus buffer edge give the two-cycle flow-through
   always_ff @(posedge core_clk) begin
      if (clearing) begin
         mb_vld_q  <= 1'b0;
         mb_data_q <= DATA_RESET;
         mb_tag_q  <= QSEL_RESET;
      end else if (mb_take) begin
         mb_vld_q  <= 1'b1;
         mb_data_q <= lnk.write_data;
         mb_tag_q  <= wq;
      end else if (mb_push) begin
         mb_vld_q  <= 1'b0;
      end
   end

   // ************************************************
   // Two-entry output buffer
   // ************************************************
   // Head slot drives the pins directly; tail absorbs a host stall
   always_ff @(posedge core_clk) begin
      if (clearing) begin
         head_vld_n_q <= 1'b1;
         head_data_q  <= DATA_RESET;
         head_tag_q   <= QSEL_RESET;
         tail_vld_q   <= 1'b0;
         tail_data_q  <= DATA_RESET;
         tail_tag_q   <= QSEL_RESET;
      end else if (buf_pop) begin
         if (tail_vld_q) begin
            head_data_q <= tail_data_q;
            head_tag_q  <= tail_tag_q;
            tail_vld_q  <= buf_push;
            tail_data_q <= push_data;
            tail_tag_q  <= push_tag;
         end else begin
            head_vld_n_q <= ~buf_push;
            head_data_q  <= push_data;
            head_tag_q   <= push_tag;
         end
      end else if (buf_push) begin
         if (head_vld_n_q) begin
            head_vld_n_q <= 1'b0;
            head_data_q  <= push_data;
            head_tag_q   <= push_tag;
         end else begin
            tail_vld_q  <= 1'b1;
            tail_data_q <= push_data;
            tail_tag_q  <= push_tag;
         end
      end
   end

   // ************************************************
   // Flags and status
   // ************************************************
   // Flags lag the pointers by one edge; the memory write gate is exact
   always_ff @(posedge core_clk) begin
      if (clearing) begin
         full_n_q       <= 1'b1;
         empty_n_q      <= 1'b0;
         mark_valid_any <= 1'b0;
      end else begin
         full_n_q       <= ~wq_full;
         empty_n_q      <= ~rq_empty;
         mark_valid_any <= |mark_vld_q;
      end
   end

   // Pins straight from the flip-flops
   assign lnk.read_data      = head_data_q;
   assign lnk.output_valid_n = head_vld_n_q;
   assign lnk.queue_tag      = head_tag_q;
   assign lnk.full_flag_n    = full_n_q;
   assign lnk.empty_flag_n   = empty_n_q;
   assign port_width_active  = width_q;
endmodule

// >>> hw/mqf_host.sv
// Host end: registers user requests onto the link and captures read words
`timescale 1ns/100ps
module mqf_host (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                reset,
   // Link to the device
   mqf_if.hst                       lnk,
   // User write request
   input  wire logic                usr_wr_en,
   input  wire mqf_pkg::mqf_word_t  usr_wr_data,
   input  wire mqf_pkg::mqf_qsel_t  usr_wr_queue,
   // User read request
   input  wire logic                usr_rd_en,
   input  wire mqf_pkg::mqf_qsel_t  usr_rd_queue,
   input  wire logic                usr_mark,
   input  wire logic                usr_retransmit,
   input  wire logic                usr_ready,
   // User mode and configuration
   input  wire logic                usr_mailbox,
   input  wire logic                usr_clear,
   input  wire logic [mqf_pkg::PW_W-1:0] usr_width,
   // User read result
   output mqf_pkg::mqf_word_t       usr_rd_data,
   output mqf_pkg::mqf_qsel_t       usr_rd_tag,
   output logic                     usr_rd_valid,
   output logic                     usr_full_n,
   output logic                     usr_empty_n
);
   import mqf_pkg::*;

   // ************************************************
   // Request registers
   // ************************************************
   logic       wr_en_q, rd_en_q, mark_q, retx_q, ready_q, mb_q, clear_q;
   mqf_word_t  wr_data_q;
   mqf_qsel_t  wq_q, rq_q;
   logic [PW_W-1:0] width_q;

   // Word accepted on the link this cycle
   wire logic  accept = ~lnk.output_valid_n & ready_q;

   // Every link output is driven from a flip-flop
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_en_q   <= 1'b0;
         wr_data_q <= DATA_RESET;
         wq_q      <= QSEL_RESET;
         rd_en_q   <= 1'b0;
         rq_q      <= QSEL_RESET;
         mark_q    <= 1'b0;
         retx_q    <= 1'b0;
         ready_q   <= 1'b0;
         mb_q      <= 1'b0;
         clear_q   <= 1'b0;
         width_q   <= PW_RESET;
      end else begin
         wr_en_q   <= usr_wr_en;
         wr_data_q <= usr_wr_data;
         wq_q      <= usr_wr_queue;
         rd_en_q   <= usr_rd_en;
         rq_q      <= usr_rd_queue;
         mark_q    <= usr_mark;
         retx_q    <= usr_retransmit;
         ready_q   <= usr_ready;
         mb_q      <= usr_mailbox;
         clear_q   <= usr_clear;
         width_q   <= usr_width;
      end
   end

   // ************************************************
   // Read capture
   // ************************************************
   // Tag is only looked at together with a valid word
   always_ff @(posedge core_clk) begin
      if (reset) begin
         usr_rd_valid <= 1'b0;
         usr_rd_data  <= DATA_RESET;
         usr_rd_tag   <= QSEL_RESET;
         usr_full_n   <= 1'b1;
         usr_empty_n  <= 1'b0;
      end else begin
         usr_rd_valid <= accept;
         usr_full_n   <= lnk.full_flag_n;
         usr_empty_n  <= lnk.empty_flag_n;
         if (accept) begin
            usr_rd_data <= lnk.read_data;
            usr_rd_tag  <= lnk.queue_tag;
         end
      end
   end

   assign lnk.write_en            = wr_en_q;
   assign lnk.write_data          = wr_data_q;
   assign lnk.write_queue_select  = wq_q;
   assign lnk.read_en             = rd_en_q;
   assign lnk.read_queue_select   = rq_q;
   assign lnk.mark                = mark_q;
   assign lnk.retransmit_request  = retx_q;
   assign lnk.data_ready          = ready_q;
   assign lnk.mailbox_path_select = mb_q;
   assign lnk.master_clear        = clear_q;
   assign lnk.port_width_select   = width_q;
endmodule

// >>> hw/mqf_if.sv
// Interface joining the host controller and the FIFO device
`timescale 1ns/100ps
interface mqf_if;
   import mqf_pkg::*;
   // Write side
   logic                write_en;
   mqf_word_t           write_data;
   mqf_qsel_t           write_queue_select;
   logic                full_flag_n;
   // Read side
   logic                read_en;
   mqf_qsel_t           read_queue_select;
   logic                mark;
   logic                retransmit_request;
   logic                data_ready;
   mqf_word_t           read_data;
   logic                output_valid_n;
   mqf_qsel_t           queue_tag;
   logic                empty_flag_n;
   // Mode and configuration
   logic                mailbox_path_select;
   logic                master_clear;
   logic [PW_W-1:0]     port_width_select;

   modport dev (
      input  write_en, write_data, write_queue_select,
      input  read_en, read_queue_select, mark, retransmit_request,
      input  data_ready, mailbox_path_select, master_clear,
      input  port_width_select,
      output full_flag_n, read_data, output_valid_n, queue_tag,
      output empty_flag_n
   );
   modport hst (
      output write_en, write_data, write_queue_select,
      output read_en, read_queue_select, mark, retransmit_request,
      output data_ready, mailbox_path_select, master_clear,
      output port_width_select,
      input  full_flag_n, read_data, output_valid_n, queue_tag,
      input  empty_flag_n
   );
endinterface

// >>> hw/mqf_pkg.sv
// Shared constants for the multi-queue FIFO side controls
package mqf_pkg;
   // ************************************************
   // Widths and sizes
   // ************************************************
   localparam int DATA_W  = 36;
   localparam int QSEL_W  = 3;
   localparam int NUM_Q   = 8;
   localparam int PTR_W   = 4;            // Words per queue is 2**PTR_W
   localparam int Q_DEPTH = 16;
   localparam int PW_W    = 3;
   localparam int ADDR_W  = QSEL_W + PTR_W;
   // ************************************************
   // Reset values and timing
   // ************************************************
   localparam logic [PW_W-1:0]   PW_RESET   = 3'h0;
   localparam logic [QSEL_W-1:0] QSEL_RESET = 3'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;
   localparam logic [PTR_W:0]    PTR_RESET  = 5'h0;
   localparam logic [PTR_W:0]    DEPTH_CNT  = 5'h10;
   localparam int MB_LAT_CYC = 2;         // Mailbox write-to-output edges

   typedef logic [DATA_W-1:0] mqf_word_t;
   typedef logic [QSEL_W-1:0] mqf_qsel_t;
   typedef logic [PTR_W:0]    mqf_ptr_t;
endpackage

// >>> tb/mqf_properties.sv
// Checker for the link between the FIFO host and device ends
`timescale 1ns/100ps
module mqf_properties (
   // Clock and reset
   input wire logic                     core_clk,
   input wire logic                     reset,
   // Driven by the host end
   input wire logic                     write_en,
   input wire mqf_pkg::mqf_word_t       write_data,
   input wire mqf_pkg::mqf_qsel_t       write_queue_select,
   input wire logic                     data_ready,
   input wire logic                     mark,
   input wire logic                     mailbox_path_select,
   input wire logic                     master_clear,
   input wire logic [mqf_pkg::PW_W-1:0] port_width_select,
   // Driven by the device end
   input wire mqf_pkg::mqf_word_t       read_data,
   input wire logic                     output_valid_n,
   input wire mqf_pkg::mqf_qsel_t       queue_tag,
   input wire logic                     full_flag_n,
   input wire logic                     empty_flag_n,
   input wire logic [mqf_pkg::PW_W-1:0] port_width_active,
   input wire logic                     mark_valid_any
);
   import mqf_pkg::*;
   // ************
   // Properties
   // ************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // Stalled head word and its tag stand still
   property p_head_hold;
      !output_valid_n && !data_ready && !master_clear |=> !output_valid_n
         && $stable(read_data) && $stable(queue_tag);
   endproperty
   a_head_hold: assert property (p_head_hold)
      else $error("stalled head word changed");
   // Valid drops only after an accept or a master clear; reset is listed for its release
   property p_valid_drop;
      $rose(output_valid_n) |-> $past(data_ready || master_clear || reset);
   endproperty
   a_valid_drop: assert property (p_valid_drop)
      else $error("output valid dropped without accept");
   // A lone mailbox word shows two edges later with its write queue
   property p_mb_lat;
      write_en && mailbox_path_select && output_valid_n && !master_clear
         && !$past(write_en && mailbox_path_select) ##1 !master_clear
         |=> !output_valid_n && read_data == $past(write_data, 2)
         && queue_tag == $past(write_queue_select, 2);
   endproperty
   a_mb_lat: assert property (p_mb_lat)
      else $error("mailbox word late or wrong");
   // An idle mailbox path lets no queue word out
   property p_mb_quiet;
      mailbox_path_select && !write_en && output_valid_n
         && !$past(write_en && mailbox_path_select) |=> output_valid_n;
   endproperty
   a_mb_quiet: assert property (p_mb_quiet)
      else $error("word appeared while mailbox idle");
   // Width is taken at clear release and nowhere else
   property p_width_cap;
      $fell(master_clear) |=> port_width_active == $past(port_width_select);
   endproperty
   a_width_cap: assert property (p_width_cap)
      else $error("width not taken at clear release");
   property p_width_hold;
      !$fell(master_clear) |=> $stable(port_width_active);
   endproperty
   a_width_hold: assert property (p_width_hold)
      else $error("width changed outside clear release");
   // A mark is recorded; the status flop adds one edge
   property p_mark_seen;
      mark && !mailbox_path_select && !master_clear ##1 !master_clear
         |=> mark_valid_any;
   endproperty
   a_mark_seen: assert property (p_mark_seen)
      else $error("mark not recorded");
   // A held clear leaves output and flags idle
   property p_clear;
      master_clear [*2] |=> output_valid_n && !empty_flag_n && full_flag_n
         && read_data == 36'h0 && queue_tag == 3'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear left output or flags set");
   // Main scenarios reached
   c_mailbox: cover property (write_en && mailbox_path_select);
   c_stall: cover property (!output_valid_n && !data_ready);
   c_release: cover property ($fell(master_clear));
endmodule

// >>> tb/testbench.sv
// Bench joining the FIFO host and device ends through the link
`timescale 1ns/100ps
module testbench;
   import mqf_pkg::*;
   // ************
   // Signals and instances
   // ************
   logic            core_clk, reset, usr_wr_en, usr_rd_en, usr_mark;
   logic            usr_retransmit, usr_ready, usr_mailbox, usr_clear;
   logic            usr_rd_valid, usr_full_n, mark_valid_any;
   mqf_word_t       usr_wr_data, usr_rd_data;
   mqf_qsel_t       usr_wr_queue, usr_rd_queue, usr_rd_tag;
   logic [PW_W-1:0] usr_width, port_width_active;
   int              error_cnt, compares;
   mqf_if u_mqf_if ();
   mqf_device u_mqf_device (.core_clk(core_clk), .reset(reset),
      .lnk(u_mqf_if.dev), .port_width_active(port_width_active),
      .mark_valid_any(mark_valid_any));
   mqf_host u_mqf_host (.core_clk(core_clk), .reset(reset),
      .lnk(u_mqf_if.hst), .usr_wr_en(usr_wr_en), .usr_wr_data(usr_wr_data),
      .usr_wr_queue(usr_wr_queue), .usr_rd_en(usr_rd_en),
      .usr_rd_queue(usr_rd_queue), .usr_mark(usr_mark),
      .usr_retransmit(usr_retransmit), .usr_ready(usr_ready),
      .usr_mailbox(usr_mailbox), .usr_clear(usr_clear),
      .usr_width(usr_width), .usr_rd_data(usr_rd_data),
      .usr_rd_tag(usr_rd_tag), .usr_rd_valid(usr_rd_valid),
      .usr_full_n(usr_full_n), .usr_empty_n());
   mqf_properties u_mqf_properties (.core_clk(core_clk), .reset(reset),
      .write_en(u_mqf_if.write_en), .write_data(u_mqf_if.write_data),
      .write_queue_select(u_mqf_if.write_queue_select),
      .data_ready(u_mqf_if.data_ready), .mark(u_mqf_if.mark),
      .mailbox_path_select(u_mqf_if.mailbox_path_select),
      .master_clear(u_mqf_if.master_clear),
      .port_width_select(u_mqf_if.port_width_select),
      .read_data(u_mqf_if.read_data), .queue_tag(u_mqf_if.queue_tag),
      .output_valid_n(u_mqf_if.output_valid_n),
      .full_flag_n(u_mqf_if.full_flag_n),
      .empty_flag_n(u_mqf_if.empty_flag_n),
      .port_width_active(port_width_active),
      .mark_valid_any(mark_valid_any));
   // ************
   // Tasks
   // ************
   task automatic close_out;
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [35:0] seen,
                        input logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One write per clock; the enable stays up until wr_end
   task automatic wr(input mqf_qsel_t q, input mqf_word_t d);
      @(negedge core_clk);
      usr_wr_en = 1'b1;
      usr_wr_queue = q;
      usr_wr_data = d;
   endtask
   task automatic wr_end;
      @(negedge core_clk);
      usr_wr_en = 1'b0;
   endtask
   // Read request pulse; the queue select is left standing for marks
   task automatic rd_req(input mqf_qsel_t q);
      @(negedge core_clk);
      usr_rd_en = 1'b1;
      usr_rd_queue = q;
      @(negedge core_clk);
      usr_rd_en = 1'b0;
   endtask
   // Bounded wait for the next accepted word
   task automatic get_word(input mqf_word_t d, input mqf_qsel_t t);
      int n;
      n = 0;
      @(negedge core_clk);
      while (usr_rd_valid !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      // A word that never arrives counts against the run
      check("rd_valid", 36'(usr_rd_valid), 36'h1);
      check("rd_data", usr_rd_data, d);
      check("rd_tag", 36'(usr_rd_tag), 36'(t));
   endtask
   task automatic rd(input mqf_qsel_t q, input mqf_word_t d);
      rd_req(q);
      get_word(d, q);
   endtask
   // ************
   // Clock, watchdog and tests
   // ************
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Whole run is under 2000 cycles; 4000 means a hang
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end
   initial begin
      {error_cnt, compares} = '0;
      {reset, usr_wr_en, usr_rd_en, usr_mark, usr_retransmit} = 5'h10;
      {usr_mailbox, usr_clear, usr_ready} = 3'h1;
      {usr_wr_data, usr_wr_queue, usr_rd_queue, usr_width} = '0;
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      repeat (2) @(negedge core_clk);
      check("valid_n", u_mqf_if.output_valid_n, 36'h1);
      // Width taken at clear release; later changes are ignored
      usr_width = 3'h5;
      usr_clear = 1'b1;
      repeat (2) @(negedge core_clk);
      usr_clear = 1'b0;
      repeat (4) @(negedge core_clk);
      usr_width = 3'h2;
      repeat (4) @(negedge core_clk);
      check("width", port_width_active, 36'h5);
      // One word into each queue, read back in reverse order
      for (int q = 0; q < NUM_Q; q++) wr(3'(q), 36'ha00 + 36'(q));
      wr_end();
      for (int q = NUM_Q - 1; q >= 0; q--) rd(3'(q), 36'ha00 + 36'(q));
      // Receiver stalls with two words buffered
      wr(3'h3, 36'h31);
      wr(3'h3, 36'h32);
      wr_end();
      usr_ready = 1'b0;
      rd_req(3'h3);
      rd_req(3'h3);
      repeat (4) @(negedge core_clk);
      check("valid_n", u_mqf_if.output_valid_n, 36'h0);
      check("head", u_mqf_if.read_data, 36'h31);
      check("tag", 36'(u_mqf_if.queue_tag), 36'h3);
      usr_ready = 1'b1;
      get_word(36'h31, 3'h3);
      get_word(36'h32, 3'h3);
      // Mark the head of queue 1, read on, then retransmit from it
      wr(3'h1, 36'h1a);
      wr(3'h1, 36'h1b);
      wr(3'h1, 36'h1c);
      wr_end();
      usr_rd_queue = 3'h1;
      usr_mark = 1'b1;
      @(negedge core_clk);
      usr_mark = 1'b0;
      repeat (3) @(negedge core_clk);
      check("marked", 36'(mark_valid_any), 36'h1);
      rd(3'h1, 36'h1a);
      rd(3'h1, 36'h1b);
      usr_retransmit = 1'b1;
      @(negedge core_clk);
      usr_retransmit = 1'b0;
      rd(3'h1, 36'h1a);
      // Retransmit aimed at unmarked queue 2 leaves queue 1 alone
      usr_rd_queue = 3'h2;
      usr_retransmit = 1'b1;
      @(negedge core_clk);
      usr_retransmit = 1'b0;
      rd(3'h1, 36'h1b);
      // Mailbox word bypasses queue 6
      usr_mailbox = 1'b1;
      wr(3'h6, 36'h6cafe);
      wr_end();
      get_word(36'h6cafe, 3'h6);
      repeat (2) @(negedge core_clk);
      usr_mailbox = 1'b0;
      usr_rd_queue = 3'h6;
      repeat (4) @(negedge core_clk);
      check("q6_empty", u_mqf_if.empty_flag_n, 36'h0);
      // Overfill queue 0 by one word, then drain it
      for (int i = 0; i <= Q_DEPTH; i++) wr(3'h0, 36'h100 + 36'(i));
      wr_end();
      repeat (4) @(negedge core_clk);
      check("full_n", usr_full_n, 36'h0);
      for (int i = 0; i < Q_DEPTH; i++) rd(3'h0, 36'h100 + 36'(i));
      repeat (4) @(negedge core_clk);
      check("empty_n", u_mqf_if.empty_flag_n, 36'h0);
      close_out();
   end
endmodule
